// >>> design/therm_cfg_defines.svh
// Register offsets, reset values, field positions and timing counts
`ifndef THERM_CFG_DEFINES_SVH
`define THERM_CFG_DEFINES_SVH

// ==========================================================
// Register offsets
`define OFS_ASSERT_TIME_LIMIT  8'h7A
`define OFS_FAN_PULSE_SELECT   8'h7B
`define OFS_CONFIG_FOUR        8'h7D
`define OFS_FACTORY_TEST_ONE   8'h7E
`define OFS_FACTORY_TEST_TWO   8'h7F
`define OFS_DURATION_STATUS    8'h79
`define OFS_IRQ_STATUS         8'h42
`define OFS_IRQ_MASK           8'h75
`define OFS_LOCK_CTRL          8'h40

// ==========================================================
// Reset values
`define RST_ASSERT_TIME_LIMIT  8'h00
`define RST_FAN_PULSE_SELECT   8'h55
`define RST_CONFIG_FOUR        8'h00
`define RST_FACTORY_TEST       8'h00

// ==========================================================
// Field positions
`define BIT_TIMER_EVENT        5
`define BIT_LOCK               1
`define BIT_ALERT_SELECT       0
`define CFG4_WRITABLE_MASK     8'h0D

// ==========================================================
// Timing: one step is 22.76 ms, kept in microseconds
`define STEP_TIME_US           22760
`define CLOCK_MHZ              200
`define STEP_CYCLES            (`STEP_TIME_US * `CLOCK_MHZ)

`endif

// >>> design/therm_cfg_pkg.sv
// Types shared by the thermal limit configuration block
`default_nettype none
package therm_cfg_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        TIM_IDLE,
        TIM_RUN,
        TIM_DONE
    } timer_state_t;
endpackage
`default_nettype wire

// >>> design/therm_limit_fan_tach_config.sv
// Thermal assertion-time limit, fan pulse and pin configuration registers
//
// Local design decision: strobed register access.
`include "therm_cfg_defines.svh"
`default_nettype none
module therm_limit_fan_tach_config
    import therm_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = `STEP_CYCLES
) (
    input  wire logic       CLOCK,
    input  wire logic       RST_N,
    input  wire logic       CLK_EN,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       THERM_ACTIVE,
    input  wire logic       FOURTH_SPEED_INPUT_IS_THERM,
    output logic      [7:0] FAN_PULSE_COUNTS,
    output logic            ALERT_ON_VOLT_PIN_SELECT,
    output logic      [1:0] TWO_WIRE_TACH_THRESHOLD,
    output logic            IRQ
);

    // ======================================================
    // Bus decode
    reg_req_t req;
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    wire hit_limit  = req.addr == `OFS_ASSERT_TIME_LIMIT;
    wire hit_pulse  = req.addr == `OFS_FAN_PULSE_SELECT;
    wire hit_cfg4   = req.addr == `OFS_CONFIG_FOUR;
    wire hit_status = req.addr == `OFS_DURATION_STATUS;
    wire hit_irq    = req.addr == `OFS_IRQ_STATUS;
    wire hit_mask   = req.addr == `OFS_IRQ_MASK;
    wire hit_lock   = req.addr == `OFS_LOCK_CTRL;

    logic [7:0]   assert_time_limit_field_reg;
    logic [7:0]   fan_pulse_reg;
    logic [7:0]   cfg4_reg;
    logic [7:0]   lock_reg;
    logic [7:0]   irq_status_reg;
    logic [7:0]   irq_mask_reg;
    logic [7:0]   assert_duration_count_reg;
    logic         assert_seen_flag_reg;
    logic [31:0]  step_cnt_reg;
    logic         fired_reg;
    timer_state_t state_reg;
    logic         therm_q_reg;

    wire lock_set = lock_reg[`BIT_LOCK];
    wire status_read = req.rd && hit_status;

    // ======================================================
    // Configuration registers
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            assert_time_limit_field_reg <= `RST_ASSERT_TIME_LIMIT;
            fan_pulse_reg <= `RST_FAN_PULSE_SELECT;
            cfg4_reg      <= `RST_CONFIG_FOUR;
            lock_reg      <= 8'h00;
            irq_mask_reg  <= 8'h00;
        end else if (CLK_EN && req.wr) begin
            if (hit_limit)
                assert_time_limit_field_reg <= req.wdata;
            if (hit_pulse)
                fan_pulse_reg <= req.wdata;
            if (hit_cfg4 && !lock_set)
                cfg4_reg <= req.wdata & `CFG4_WRITABLE_MASK;
            if (hit_lock)
                lock_reg <= req.wdata | (lock_reg & 8'h02);
            if (hit_mask)
                irq_mask_reg <= req.wdata;
        end
    end

    // ======================================================
    // Assertion-duration timer
    wire step_tick = step_cnt_reg == 32'(STEP_CYCLES - 1);
    wire therm_rise = THERM_ACTIVE && !therm_q_reg;
    wire over_limit = assert_duration_count_reg >
                      assert_time_limit_field_reg;
    // zero limit
    // Zero limit fires at the rise, only from idle, so an earlier run must first be closed by a status read
    wire zero_hit = therm_rise && state_reg == TIM_IDLE &&
                    assert_time_limit_field_reg == 8'h00;
    wire limit_event = zero_hit ||
                       (state_reg == TIM_RUN && !fired_reg &&
                        THERM_ACTIVE && over_limit);

    logic [7:0] count_next;
    always_comb begin
        count_next = assert_duration_count_reg;
        if (state_reg == TIM_RUN && step_tick &&
            assert_duration_count_reg != 8'hFF)
            count_next = assert_duration_count_reg + 8'h01;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_reg                 <= TIM_IDLE;
            step_cnt_reg              <= 32'h0;
            assert_duration_count_reg <= 8'h00;
            assert_seen_flag_reg      <= 1'b0;
            fired_reg                 <= 1'b0;
            therm_q_reg               <= 1'b0;
        end else if (CLK_EN) begin
            therm_q_reg <= THERM_ACTIVE;
            if (limit_event)
                fired_reg <= 1'b1;
            case (state_reg)
                TIM_IDLE: begin
                    if (therm_rise) begin
                        state_reg <= TIM_RUN;
                        step_cnt_reg <= 32'h0;
                        assert_duration_count_reg <= 8'h00;
                        fired_reg <= zero_hit;
                    end
                end
                TIM_RUN: begin
                    step_cnt_reg <= step_tick ? 32'h0
                                              : step_cnt_reg + 32'h1;
                    assert_duration_count_reg <= count_next;
                    if (!THERM_ACTIVE)
                        state_reg <= TIM_DONE;
                end
                TIM_DONE: begin
                    if (status_read)
                        state_reg <= TIM_IDLE;
                end
                default: state_reg <= TIM_IDLE;
            endcase
            if (therm_rise)
                assert_seen_flag_reg <= 1'b1;
            else if (status_read)
                assert_seen_flag_reg <= 1'b0;
        end
    end

    wire [7:0] status_view = (assert_duration_count_reg >= 8'h02)
        ? assert_duration_count_reg
        : {7'h00, assert_seen_flag_reg};

    // ======================================================
    // Interrupt status, mask and output
    wire [7:0] irq_set = {2'b00, limit_event, 5'b00000};
    wire [7:0] irq_clr = (CLK_EN && req.wr && hit_irq) ? req.wdata : 8'h00;

    always_ff @(posedge CLOCK) begin
        if (!RST_N)
            irq_status_reg <= 8'h00;
        else if (CLK_EN)
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
    end

    wire timer_masked = irq_mask_reg[`BIT_TIMER_EVENT] &&
                        FOURTH_SPEED_INPUT_IS_THERM;
    wire [7:0] eff_mask = irq_mask_reg |
        (timer_masked ? 8'h20 : 8'h00);
    assign IRQ = |(irq_status_reg & ~eff_mask);

    // ======================================================
    // Read data and pin controls
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_limit)  rd_mux = assert_time_limit_field_reg;
        if (hit_pulse)  rd_mux = fan_pulse_reg;
        if (hit_cfg4)   rd_mux = cfg4_reg;
        if (hit_status) rd_mux = status_view;
        if (hit_irq)    rd_mux = irq_status_reg;
        if (hit_mask)   rd_mux = irq_mask_reg;
        if (hit_lock)   rd_mux = lock_reg;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N)
            RDATA <= 8'h00;
        else if (CLK_EN)
            RDATA <= req.rd ? rd_mux : 8'h00;
    end

    assign FAN_PULSE_COUNTS = fan_pulse_reg;
    assign ALERT_ON_VOLT_PIN_SELECT = cfg4_reg[`BIT_ALERT_SELECT];
    assign TWO_WIRE_TACH_THRESHOLD = cfg4_reg[3:2];

    // ======================================================
    // Checks
    AST_RESET_PULSE: assert property (@(posedge CLOCK)
        $rose(RST_N) |-> fan_pulse_reg == 8'h55)
        else $error("pulse register not 0x55 after reset");
    AST_LOCK_HOLDS: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && WR && hit_cfg4 && lock_set) |=> $stable(cfg4_reg))
        else $error("locked config register changed");
    AST_CFG4_WRITE: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && WR && hit_cfg4 && !lock_set) |=>
        ALERT_ON_VOLT_PIN_SELECT == $past(WDATA[0]))
        else $error("pin select not written");
    AST_THRESH_WRITE: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && WR && hit_cfg4 && !lock_set) |=>
        TWO_WIRE_TACH_THRESHOLD == $past(WDATA[3:2]))
        else $error("threshold not written");
    AST_EVENT_SETS: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && limit_event) |=> irq_status_reg[5])
        else $error("limit event did not set status bit 5");
    AST_ZERO_LIMIT: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && state_reg == TIM_IDLE && therm_rise &&
         assert_time_limit_field_reg == 8'h00) |=> irq_status_reg[5])
        else $error("zero limit did not raise event at once");
    AST_FIRE_ONCE: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (fired_reg && state_reg != TIM_IDLE) |-> !limit_event)
        else $error("limit event fired twice");
    AST_FLAG_CLEAR: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && status_read && !therm_rise) |=>
        !assert_seen_flag_reg)
        else $error("seen flag not cleared by read");
    AST_TEST_ZERO: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && RD && ADDR >= `OFS_FACTORY_TEST_ONE) |=> RDATA == 8'h00)
        else $error("test register read nonzero");
    AST_MASKED: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (irq_status_reg == 8'h20 && irq_mask_reg[5] &&
         FOURTH_SPEED_INPUT_IS_THERM) |-> !IRQ)
        else $error("masked timer event raised interrupt");
    AST_LIMIT_RW: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && WR && hit_limit) |=>
        assert_time_limit_field_reg == $past(WDATA))
        else $error("limit register not written");
    AST_PULSE_RW: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && WR && hit_pulse) |=> FAN_PULSE_COUNTS == $past(WDATA))
        else $error("pulse register not written");

    AST_RDATA_IDLE: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && !RD) |=> RDATA == 8'h00)
        else $error("read data not zero outside a read");

    AST_LIMIT_READ: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && RD && hit_limit) |=>
        RDATA == $past(assert_time_limit_field_reg))
        else $error("limit register read wrong");

    AST_PULSE_READ: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && RD && hit_pulse) |=> RDATA == $past(fan_pulse_reg))
        else $error("pulse register read wrong");

    AST_CFG4_RESERVED: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        cfg4_reg[7:4] == 4'h0 && !cfg4_reg[1])
        else $error("reserved config bits set");

    AST_LOCK_STICKY: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        lock_set |=> lock_set)
        else $error("lock bit cleared without reset");

    AST_CFG4_READ: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && RD && hit_cfg4) |=> RDATA == $past(cfg4_reg))
        else $error("config register read wrong");

    AST_STATUS_STICKY: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (irq_status_reg[5] && !(CLK_EN && WR && hit_irq && WDATA[5]))
        |=> irq_status_reg[5])
        else $error("status bit 5 lost without clear");

    AST_STATUS_CLEAR: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && WR && hit_irq && WDATA[5] && !limit_event)
        |=> !irq_status_reg[5])
        else $error("status bit 5 not cleared by write");

    AST_ONLY_BIT5: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        irq_status_reg[7:6] == 2'b00 && irq_status_reg[4:0] == 5'h00)
        else $error("unexpected status bit set");

    AST_COUNT_SAT: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && state_reg == TIM_RUN &&
         assert_duration_count_reg == 8'hFF) |=>
        assert_duration_count_reg == 8'hFF)
        else $error("duration count wrapped");

    AST_COUNT_STEP: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && state_reg == TIM_RUN && step_tick &&
         assert_duration_count_reg != 8'hFF) |=>
        assert_duration_count_reg == $past(assert_duration_count_reg) + 8'h01)
        else $error("duration count missed a step");

    AST_FLAG_SET: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && therm_rise) |=> assert_seen_flag_reg)
        else $error("seen flag not set on assertion");

    AST_STATUS_VIEW: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (CLK_EN && RD && hit_status && assert_duration_count_reg < 8'h02)
        |=> RDATA == {7'h00, $past(assert_seen_flag_reg)})
        else $error("short assertion status read wrong");

    AST_IRQ_LEVEL: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        (irq_status_reg[5] && !irq_mask_reg[5]) |-> IRQ)
        else $error("unmasked event gave no interrupt");

endmodule
`default_nettype wire

// >>> testbench/reg_host.sv
// Register bus host model for the plain register port
`default_nettype none
module reg_host
    import therm_cfg_pkg::*;
(
    input  wire logic       clock,
    input  wire logic [7:0] rdata,
    output var  reg_req_t   req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // ==========================================================
    // Bus cycles
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        if (a[7:1] != 7'h3F) begin
            req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
            @(posedge clock);
            req.wr <= 1'b0;
        end
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule
`default_nettype wire

// >>> testbench/therm_limit_fan_tach_config_test.sv
// Self-checking bench for the thermal limit configuration block
`default_nettype none
module therm_limit_fan_tach_config_test
    import therm_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       therm = 1'b0;
    logic       fourth_therm = 1'b0;
    reg_req_t   req;
    logic [7:0] rdata;
    logic [7:0] fan_counts;
    logic       alert_sel;
    logic [1:0] threshold;
    logic       irq;
    int         bad_count = 0;
    int         comparisons = 0;
    int         cycles = 0;

    always #2.5 clock = ~clock;

    therm_limit_fan_tach_config #(
        .STEP_CYCLES(8)
    ) i_therm_limit_fan_tach_config (
        .CLOCK(clock), .RST_N(rst_n), .CLK_EN(1'b1),
        .ADDR(req.addr), .WDATA(req.wdata), .WR(req.wr), .RD(req.rd),
        .RDATA(rdata), .THERM_ACTIVE(therm),
        .FOURTH_SPEED_INPUT_IS_THERM(fourth_therm),
        .FAN_PULSE_COUNTS(fan_counts), .ALERT_ON_VOLT_PIN_SELECT(alert_sel),
        .TWO_WIRE_TACH_THRESHOLD(threshold), .IRQ(irq)
    );

    reg_host i_reg_host (.clock(clock), .rdata(rdata), .req(req));

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_reg_host.read_reg(a, d);
        check(d, exp);
    endtask

    task automatic do_reset();
        @(posedge clock) rst_n <= 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Scenarios
    task automatic test_reset_values();
        rd_check(8'h7A, 8'h00);
        rd_check(8'h7B, 8'h55);
        check(fan_counts, 8'h55);
        rd_check(8'h7D, 8'h00);
        rd_check(8'h7E, 8'h00);
        rd_check(8'h7F, 8'h00);
        rd_check(8'h10, 8'h00);
        $display("test reset values done");
    endtask

    task automatic test_limit_and_fans();
        i_reg_host.write_reg(8'h7A, 8'hFF);
        rd_check(8'h7A, 8'hFF);
        i_reg_host.write_reg(8'h7A, 8'h00);
        rd_check(8'h7A, 8'h00);
        for (int c = 0; c < 4; c++) begin
            i_reg_host.write_reg(8'h7B, {4{c[1:0]}});
            rd_check(8'h7B, {4{c[1:0]}});
            check(fan_counts, {4{c[1:0]}});
        end
        $display("test limit and fan fields done");
    endtask

    task automatic test_config_four();
        for (int c = 0; c < 4; c++) begin
            i_reg_host.write_reg(8'h7D, {4'hF, c[1:0], 2'b11});
            rd_check(8'h7D, {4'h0, c[1:0], 2'b01});
            check({6'h00, threshold}, {6'h00, c[1:0]});
            check({7'h00, alert_sel}, 8'h01);
        end
        i_reg_host.write_reg(8'h7D, 8'h00);
        @(negedge clock);
        check({7'h00, alert_sel}, 8'h00);
        i_reg_host.write_reg(8'h40, 8'h02);
        i_reg_host.write_reg(8'h7D, 8'h0D);
        rd_check(8'h7D, 8'h00);
        check({7'h00, alert_sel}, 8'h00);
        $display("test config four and lock done");
    endtask

    task automatic test_timer();
        do_reset();
        fourth_therm <= 1'b1;
        @(posedge clock) therm <= 1'b1;
        repeat (3) @(posedge clock);
        check({7'h00, irq}, 8'h01);
        rd_check(8'h79, 8'h01);
        rd_check(8'h79, 8'h00);
        rd_check(8'h42, 8'h20);
        @(posedge clock) therm <= 1'b0;
        i_reg_host.write_reg(8'h42, 8'h20);
        rd_check(8'h79, 8'h00);
        check({7'h00, irq}, 8'h00);
        i_reg_host.write_reg(8'h7A, 8'h02);
        @(posedge clock) therm <= 1'b1;
        repeat (12) @(posedge clock);
        check({7'h00, irq}, 8'h00);
        repeat (20) @(posedge clock);
        check({7'h00, irq}, 8'h01);
        i_reg_host.write_reg(8'h42, 8'h20);
        repeat (20) @(posedge clock);
        check({7'h00, irq}, 8'h00);
        therm <= 1'b0;
        rd_check(8'h79, 8'h06);
        i_reg_host.write_reg(8'h75, 8'h20);
        i_reg_host.write_reg(8'h7A, 8'h00);
        @(posedge clock) therm <= 1'b1;
        repeat (4) @(posedge clock);
        check({7'h00, irq}, 8'h00);
        rd_check(8'h42, 8'h20);
        @(posedge clock) therm <= 1'b0;
        $display("test thermal timer done");
    endtask

    initial begin
        do_reset();
        test_reset_values();
        test_limit_and_fans();
        test_config_four();
        test_timer();
        tally_and_finish();
    end
endmodule
`default_nettype wire
